// ---- src/rsq_sequencer.sv ----
// Reset initialization sequencer: power-on, hard and soft reset flow with strap capture.
// Assumes i_resetn is the internal power-on reset and all inputs are synchronous to i_clock.
`timescale 1ns/100ps
`include "rsq_consts.svh"
module rsq_sequencer
	import rsq_pkg::*;
#(
	parameter int PLL_LOCK_CYC = `RSQ_PLL_LOCK_CYC,
	parameter int OUT_ASSERT   = `RSQ_OUT_ASSERT_MIN,
	parameter int HARD_TO_SOFT = `RSQ_HARD_TO_SOFT
) (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_resetn,
	// Clock mode
	input  wire logic        i_host_mode,
	input  wire logic        i_pll_locked,
	// Reset pins as inputs
	input  wire logic        i_hard_reset_n,
	input  wire logic        i_soft_reset_n,
	// Reset pins as outputs, enable low while driving
	output logic             o_hard_reset_n,
	output logic             o_hard_reset_oe_n,
	output logic             o_soft_reset_n,
	output logic             o_soft_reset_oe_n,
	// Strap pins
	input  wire rsq_strap_s  i_strap,
	output rsq_strap_s       o_strap,
	output logic             o_strap_oe_n,
	// Captured configuration
	output rsq_strap_s       o_config,
	output logic             o_sync_div2,
	output logic             o_clock_sel_host,
	output logic             o_running
);
	////////////////////////////////////////////////////////////////////////////
	rsq_state_e                state;
	rsq_state_e                next_state;
	logic [`RSQ_CNT_WIDTH-1:0] count;
	logic [`RSQ_CNT_WIDTH-1:0] next_count;
	logic                      captured;
	logic                      strap_wait;
	logic                      hard_req;
	logic                      soft_req;
	logic                      soft_only;
	// Own drive is masked, or the filters would take the device's pulse as a fresh request
	wire                       hard_level_n = i_hard_reset_n || !o_hard_reset_oe_n;
	wire                       soft_level_n = i_soft_reset_n || !o_soft_reset_oe_n;

	rsq_low_filter #(.MIN_LOW(`RSQ_IN_ASSERT_MIN)) u_hard_filter (
		.i_clock  (i_clock),
		.i_resetn (i_resetn),
		.i_level_n(hard_level_n),
		.o_long_low(hard_req)
	);
	rsq_low_filter #(.MIN_LOW(`RSQ_IN_ASSERT_MIN)) u_soft_filter (
		.i_clock  (i_clock),
		.i_resetn (i_resetn),
		.i_level_n(soft_level_n),
		.o_long_low(soft_req)
	);

	////////////////////////////////////////////////////////////////////////////
	wire count_done_pll  = (count >= `RSQ_CNT_WIDTH'(PLL_LOCK_CYC - 1));
	wire count_done_hard = (count >= `RSQ_CNT_WIDTH'(OUT_ASSERT - 1));
	wire count_done_soft = soft_only ? count_done_hard
	                                 : (count >= `RSQ_CNT_WIDTH'(HARD_TO_SOFT - 1));
	wire in_hard         = (state == RSQ_IDLE) || (state == RSQ_PLL_WAIT) || (state == RSQ_HARD);
	wire in_soft         = in_hard || (state == RSQ_SOFT);

	always_comb begin
		next_state = state;
		next_count = count + `RSQ_CNT_WIDTH'(1);
		case (state)
			RSQ_IDLE: begin
				next_state = RSQ_PLL_WAIT;
				next_count = '0;
			end
			RSQ_PLL_WAIT: begin
				// Lock may come early; the full window is the fallback
				if (i_pll_locked || count_done_pll) begin
					next_state = RSQ_HARD;
					next_count = '0;
				end
			end
			RSQ_HARD: begin
				if (count_done_hard) begin
					next_state = RSQ_SOFT;
					next_count = '0;
				end
			end
			RSQ_SOFT: begin
				if (count_done_soft) begin
					next_state = RSQ_RUN;
					next_count = '0;
				end
			end
			RSQ_RUN: begin
				next_count = '0;
				if (hard_req) begin
					next_state = RSQ_HARD;
				end else if (soft_req) begin
					next_state = RSQ_SOFT;
				end
			end
			default: begin
				next_state = RSQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= RSQ_IDLE;
			count <= '0;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Straps caught on the first edge after power-on release, then held
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			captured <= 1'b0;
			o_config <= '0;
		end else if (!captured) begin
			captured <= 1'b1;
			o_config <= i_strap;
		end
	end

	// A soft-only pulse must meet the full output assertion time
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			soft_only <= 1'b0;
		end else if (state == RSQ_RUN) begin
			soft_only <= soft_req && !hard_req;
		end
	end

	// One idle cycle after hard release before driving straps again
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			strap_wait <= 1'b1;
		end else begin
			strap_wait <= in_hard || !i_hard_reset_n;
		end
	end

	// Straps released combinationally while hard reset is active
	// Pin read directly, so an outside hard reset frees the straps before it is qualified
	assign o_strap_oe_n      = in_hard || strap_wait || !i_hard_reset_n;
	assign o_strap           = o_config;
	assign o_hard_reset_n    = !in_hard;
	assign o_hard_reset_oe_n = !in_hard;
	assign o_soft_reset_n    = !in_soft;
	assign o_soft_reset_oe_n = !in_soft;
	assign o_sync_div2       = i_host_mode && o_config.input_divider_strap;
	assign o_clock_sel_host  = i_host_mode;
	assign o_running         = (state == RSQ_RUN);

	////////////////////////////////////////////////////////////////////////////
	sequence s_hard_rise;
		$rose(o_hard_reset_n);
	endsequence

	property p_hard_len;
		@(posedge i_clock) disable iff (!i_resetn)
		$fell(o_hard_reset_n) |-> !o_hard_reset_n [*8];
	endproperty
	a_hard_len: assert property (p_hard_len) else $error("hard reset output too short");

	property p_soft_after_hard;
		@(posedge i_clock) disable iff (!i_resetn)
		s_hard_rise |-> !o_soft_reset_n [*8];
	endproperty
	a_soft_after_hard: assert property (p_soft_after_hard) else $error("soft reset released early");

	property p_strap_off;
		@(posedge i_clock) disable iff (!i_resetn)
		!o_hard_reset_n |-> o_strap_oe_n;
	endproperty
	a_strap_off: assert property (p_strap_off) else $error("straps driven in hard reset");

	property p_strap_on_delay;
		@(posedge i_clock) disable iff (!i_resetn)
		s_hard_rise |-> o_strap_oe_n ##1 !o_strap_oe_n;
	endproperty
	a_strap_on_delay: assert property (p_strap_on_delay) else $error("strap drive timing wrong");

	property p_config_hold;
		@(posedge i_clock) disable iff (!i_resetn)
		captured |=> $stable(o_config);
	endproperty
	a_config_hold: assert property (p_config_hold) else $error("captured straps changed");

	property p_hard_req;
		@(posedge i_clock) disable iff (!i_resetn)
		(o_running && hard_req) |=> !o_hard_reset_n;
	endproperty
	a_hard_req: assert property (p_hard_req) else $error("hard request ignored");

	property p_div;
		@(posedge i_clock) disable iff (!i_resetn)
		!i_host_mode |-> !o_sync_div2;
	endproperty
	a_div: assert property (p_div) else $error("divider active in agent mode");

	property p_pll;
		@(posedge i_clock) disable iff (!i_resetn)
		(state == RSQ_PLL_WAIT && i_pll_locked) |=> (state == RSQ_HARD);
	endproperty
	a_pll: assert property (p_pll) else $error("lock not followed");

	property p_soft_len;
		@(posedge i_clock) disable iff (!i_resetn)
		(o_hard_reset_n && $fell(o_soft_reset_n)) |-> !o_soft_reset_n [*8];
	endproperty
	a_soft_len: assert property (p_soft_len) else $error("soft reset output too short");

	property p_strap_pin_off;
		@(posedge i_clock) disable iff (!i_resetn)
		!i_hard_reset_n |-> o_strap_oe_n;
	endproperty
	a_strap_pin_off: assert property (p_strap_pin_off) else $error("straps driven while hard pin low");

	property p_no_retrigger;
		@(posedge i_clock) disable iff (!i_resetn)
		$rose(o_running) |=> o_running;
	endproperty
	a_no_retrigger: assert property (p_no_retrigger) else $error("own pulse taken as request");
endmodule : rsq_sequencer

// ---- src/rsq_consts.svh ----
// Constants of the reset initialization sequencer.
// Assumes one 50 MHz clock; all counts are in cycles of that clock.
// Operation
// - The primary clock is the primary clock input in host mode and the PCI clock input in agent mode.
// - Hard and soft reset outputs driven by the device stay asserted at least 512 sync clock periods.
// - Soft reset is released no earlier than 16 sync clock periods after hard reset is released.
// - While hard reset is asserted the device stops driving the strap pins within 4 ns.
// - The device waits at least one sync clock period after hard reset release before driving the straps.
// - The strap set is a three-bit reset source field and one input divider bit.
// - In host mode the sync clock period depends on the input divider strap.
// - Reset sequencing allows up to 100 us for the internal PLLs to lock.
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH

`define RSQ_CLOCK_NS        20
`define RSQ_IN_ASSERT_MIN   32
`define RSQ_STRAP_SETUP_MIN 4
`define RSQ_OUT_ASSERT_MIN  512
`define RSQ_HARD_TO_SOFT    16
`define RSQ_STRAP_ON_DELAY  1
`define RSQ_PLL_LOCK_US     100
`define RSQ_PLL_LOCK_CYC    ((`RSQ_PLL_LOCK_US * 1000) / `RSQ_CLOCK_NS)
`define RSQ_SRC_WIDTH       3
`define RSQ_CNT_WIDTH       16

`endif

// ---- src/rsq_pkg.sv ----
// Types of the reset initialization sequencer.
// Constants live in rsq_consts.svh.
package rsq_pkg;
	typedef struct packed {
		logic [2:0] reset_source;
		logic       input_divider_strap;
	} rsq_strap_s;

	typedef enum logic [2:0] {
		RSQ_IDLE,
		RSQ_PLL_WAIT,
		RSQ_HARD,
		RSQ_SOFT,
		RSQ_RUN
	} rsq_state_e;
endpackage : rsq_pkg

// ---- src/rsq_low_filter.sv ----
// Counts how long an active-low input has been low.
// Assumes the input is synchronous to i_clock.
`timescale 1ns/100ps
`include "rsq_consts.svh"
module rsq_low_filter #(
	parameter int MIN_LOW = `RSQ_IN_ASSERT_MIN
) (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_resetn,
	// Sampled level
	input  wire logic i_level_n,
	// Qualified assertion
	output logic      o_long_low
);
	logic [7:0] count;

	// Short glitches never reach the sequencer
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			count <= 8'h00;
		end else if (i_level_n) begin
			count <= 8'h00;
		end else if (count != 8'(MIN_LOW)) begin
			count <= count + 8'h01;
		end
	end

	assign o_long_low = (count == 8'(MIN_LOW));
endmodule : rsq_low_filter

// ---- verif/rsq_board.sv ----
// Board reset supervisor and strap resistors facing the sequencer.
// Assumes the bench calls its tasks between falling edges.
`timescale 1ns/100ps
module rsq_board
	import rsq_pkg::*;
(
	// Clock
	input  wire logic       i_clock,
	// Device side of the pins
	input  wire logic       i_hard_n,
	input  wire logic       i_hard_oe_n,
	input  wire logic       i_soft_n,
	input  wire logic       i_soft_oe_n,
	input  wire rsq_strap_s i_strap,
	input  wire logic       i_strap_oe_n,
	// Resolved pin levels
	output logic            o_hard_n,
	output logic            o_soft_n,
	output rsq_strap_s      o_strap
);
	logic       hard_pull_n = 1'b1;
	logic       soft_pull_n = 1'b1;
	rsq_strap_s board       = '0;
	// Open drain with pull-ups, so the device sees its own pulse too
	assign o_hard_n = hard_pull_n & (i_hard_oe_n | i_hard_n);
	assign o_soft_n = soft_pull_n & (i_soft_oe_n | i_soft_n);
	// Resistors win only while the device lets go
	assign o_strap = i_strap_oe_n ? board : i_strap;
	// Called well before power-on release, and once more while running
	task automatic set_straps(input rsq_strap_s s);
		board = s;
	endtask : set_straps
	task automatic hold_low(input bit hard, input int n);
		@(negedge i_clock);
		if (hard) hard_pull_n = 1'b0;
		else soft_pull_n = 1'b0;
		repeat (n) @(negedge i_clock);
		hard_pull_n = 1'b1;
		soft_pull_n = 1'b1;
	endtask : hold_low
endmodule : rsq_board

// ---- verif/test_reset_initialization_sequencer.sv ----
// Self-checking bench of the reset sequencer with a board model.
// Assumes shortened PLL and assertion counts.
`timescale 1ns/100ps
module test_reset_initialization_sequencer;
	import rsq_pkg::*;
	localparam int OA = 20;
	localparam int HS = 16;
	logic        i_clock = 0, i_resetn = 0, i_host_mode = 0, i_pll_locked = 0;
	logic        o_hard_n, o_hard_oe_n, o_soft_n, o_soft_oe_n, o_strap_oe_n;
	logic        o_sync_div2, o_clock_sel_host, o_running, pin_hard_n, pin_soft_n;
	rsq_strap_s  o_strap, o_config, pin_strap, s;
	int          mismatches = 0, compares = 0;
	int unsigned seed = 13260;
	rsq_sequencer #(.PLL_LOCK_CYC(20), .OUT_ASSERT(OA), .HARD_TO_SOFT(HS)) dut (.i_clock(i_clock),
		.i_resetn(i_resetn), .i_host_mode(i_host_mode), .i_pll_locked(i_pll_locked),
		.i_hard_reset_n(pin_hard_n), .i_soft_reset_n(pin_soft_n), .o_hard_reset_n(o_hard_n),
		.o_hard_reset_oe_n(o_hard_oe_n), .o_soft_reset_n(o_soft_n), .o_soft_reset_oe_n(o_soft_oe_n),
		.i_strap(pin_strap), .o_strap(o_strap), .o_strap_oe_n(o_strap_oe_n), .o_config(o_config),
		.o_sync_div2(o_sync_div2), .o_clock_sel_host(o_clock_sel_host), .o_running(o_running));
	rsq_board board (.i_clock(i_clock), .i_hard_n(o_hard_n), .i_hard_oe_n(o_hard_oe_n),
		.i_soft_n(o_soft_n), .i_soft_oe_n(o_soft_oe_n), .i_strap(o_strap), .i_strap_oe_n(o_strap_oe_n),
		.o_hard_n(pin_hard_n), .o_soft_n(pin_soft_n), .o_strap(pin_strap));
	initial begin
		forever #10 i_clock = ~i_clock;
	end
	////////////////////////////////////////////////////////////////
	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : finish_test
	task automatic chk_cnt(input int got, input int exp);
		compares++;
		if (got != exp) begin
			mismatches++;
			$display("BAD %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk_cnt
	task automatic chk_val(input logic [3:0] got, input logic [3:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk_val
	// Counts hard low, soft-only low and undriven strap cycles of one sequence
	task automatic run_seq(input int eh, input int es, input int eo);
		int hc = 0, sc = 0, oc = 0, bad = 0, n = 0;
		bit dropped = 0;
		while (!(dropped && o_running === 1'b1)) begin
			@(negedge i_clock);
			n++;
			if (o_running !== 1'b1) dropped = 1;
			if (o_hard_n !== 1'b1) hc++;
			else if (o_soft_n !== 1'b1) sc++;
			if ((o_hard_n !== 1'b1 || pin_hard_n !== 1'b1) && o_strap_oe_n !== 1'b1) bad++;
			if (o_hard_n === 1'b1 && o_strap_oe_n !== 1'b0 && dropped) oc++;
			if (n > 400) begin
				mismatches++;
				finish_test();
			end
		end
		if (eh >= 0) chk_cnt(hc, eh);
		chk_cnt(sc, es);
		if (eo >= 0) chk_cnt(oc, eo);
		chk_cnt(bad, 0);
	endtask : run_seq
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) begin
			s = rsq_strap_s'(4'(rnd()));
			i_resetn = 0;
			i_pll_locked = 0;
			i_host_mode = ~i_host_mode;
			board.set_straps(s);
			repeat (32) @(negedge i_clock);
			i_resetn = 1;
			fork
				begin
					// Agent passes run into the lock timeout
					repeat (rnd() % 16 + (i_host_mode ? 0 : 40)) @(negedge i_clock);
					i_pll_locked = 1;
				end
			join_none
			run_seq(-1, HS, 1);
			chk_val(o_config, s);
			chk_val({2'h0, o_sync_div2, o_clock_sel_host}, {2'h0, i_host_mode & s[0], i_host_mode});
			board.set_straps(~s);
			fork
				board.hold_low(1, 32);
				run_seq(OA, HS, 1);
			join
			chk_val(o_config, s);
			chk_val(pin_strap, s);
			fork
				board.hold_low(0, 32);
				run_seq(0, OA, -1);
			join
			board.hold_low(1, 31);
			chk_val({3'h0, o_running}, 4'h1);
		end
		finish_test();
	end
endmodule : test_reset_initialization_sequencer
